// ===== core/bit_status_pkg.sv
// Register map, field positions and reset values of the built-in test block
package bit_status_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register indices; byte address is index times four on wider buses
	localparam logic [3:0] IDX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_TEST_STATUS = 4'h6;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
	// Field positions in the test status word
	localparam int POS_MEMORY_FAIL = 15;
	localparam int POS_LOOPBACK_FAIL = 14;
	localparam int POS_ADDR_PARITY_FAIL = 13;
	localparam int POS_TEST_FAIL = 12;
	localparam int POS_CHAN_A_FAIL = 11;
	localparam int POS_CHAN_B_FAIL = 10;
	localparam int USER_FIELD_W = 10;
	localparam int POS_BUFFER_MODE = 6;
	// Hardware-set flag mask: bits 15:13 and 11:10
	localparam logic [15:0] HW_FLAG_MASK = 16'hec00;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
	// Arbitrary version code, not tied to any real product
	localparam logic [9:0] VERSION_CODE = 10'h0a5;
	localparam int IRQ_W = 5;
endpackage

// ===== core/bit_flag_cell.sv
// Sticky flag cell: hardware set wins over software write
`timescale 1ns/1ps
module bit_flag_cell #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] reset_value,
	input wire logic wr_en,
	input wire logic wr_one_clears,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [WIDTH-1:0] hw_set,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] flags_ff;
	logic [WIDTH-1:0] nxt_flags;
	logic [WIDTH-1:0] after_wr;

	// Elaboration-time refusal of an empty cell
	if (WIDTH < 1)
	begin : g_bad_width
		$error("bit_flag_cell WIDTH must be positive");
	end

	assign after_wr = !wr_en ? flags_ff :
		(wr_one_clears ? (flags_ff & ~wr_data) : wr_data);
	// Set applied last so a coinciding write never loses an event
	assign nxt_flags = after_wr | hw_set;
	assign value = flags_ff;

	// Reset value is chosen at each of the two instance sites: version code for status, zero for interrupt status
	always_ff @(posedge clk)
	begin
		if (reset)
			flags_ff <= reset_value;
		else
			flags_ff <= nxt_flags;
	end
endmodule

// ===== core/builtin_test_status_word.sv
// Built-in test status word with interrupt status and mask registers
// Behaviour
// - Memory access failure sets bit 15, the memory fail flag.
// - Loopback mismatch of transmitted words sets bit 14.
// - Terminal address parity error sets bit 13.
// - Hardware never sets bit 12; only CPU writes or reset change it.
// - Transmitter timeout on bus A sets bit 11.
// - Transmitter timeout on bus B sets bit 10.
// - Hardware never sets bits 9:0; only writes or reset change them.
// - CPU write replaces whole word; every bit settable and clearable.
// - Reset loads version code into 9:0, flags 15:10 cleared.
// - No buffered mode; control bit 6 steers nothing.
// - Message data goes straight to memory without buffering.
// - Test status word sits at register index 6.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module builtin_test_status_word (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic MEMORY_FAIL,
	input wire logic LOOPBACK_FAIL,
	input wire logic ADDR_PARITY_FAIL,
	input wire logic TIMEOUT_BUS_A,
	input wire logic TIMEOUT_BUS_B,
	output logic IRQ
);
	localparam int W = bit_status_pkg::DATA_W;

	logic [W-1:0] status_word;
	logic [W-1:0] hw_set;
	logic [W-1:0] control_ff;
	logic [W-1:0] nxt_control;
	logic [bit_status_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [bit_status_pkg::IRQ_W-1:0] nxt_irq_mask;
	logic [bit_status_pkg::IRQ_W-1:0] irq_events;
	logic [bit_status_pkg::IRQ_W-1:0] irq_status;
	logic [W-1:0] irq_status_w;
	logic [W-1:0] irq_set_w;
	logic [W-1:0] rdata_ff;
	logic [W-1:0] nxt_rdata;
	logic irq_ff;
	logic nxt_irq;
	logic wr_status;
	logic wr_control;
	logic wr_irq_status;
	logic wr_irq_mask;

	// Events come from logic on MCLK, so no synchroniser is needed
	assign hw_set = '0
		| (W'(MEMORY_FAIL) << bit_status_pkg::POS_MEMORY_FAIL)
		| (W'(LOOPBACK_FAIL) << bit_status_pkg::POS_LOOPBACK_FAIL)
		| (W'(ADDR_PARITY_FAIL)
			<< bit_status_pkg::POS_ADDR_PARITY_FAIL)
		| (W'(TIMEOUT_BUS_A) << bit_status_pkg::POS_CHAN_A_FAIL)
		| (W'(TIMEOUT_BUS_B) << bit_status_pkg::POS_CHAN_B_FAIL);
	// Bit 12 and the user field have no hardware source

	assign wr_status = WR && ADDR == bit_status_pkg::IDX_TEST_STATUS;
	assign wr_control = WR && ADDR == bit_status_pkg::IDX_CONTROL;
	assign wr_irq_status = WR && ADDR == bit_status_pkg::IDX_IRQ_STATUS;
	assign wr_irq_mask = WR && ADDR == bit_status_pkg::IDX_IRQ_MASK;

	// Full-word replace on write, hardware set on top
	bit_flag_cell #(
		.WIDTH(W)
	) u_status (
		.clk(MCLK),
		.reset(RESET),
		.reset_value({6'h00, bit_status_pkg::VERSION_CODE}),
		.wr_en(wr_status),
		.wr_one_clears(1'b0),
		.wr_data(WDATA),
		.hw_set(hw_set & bit_status_pkg::HW_FLAG_MASK),
		.value(status_word)
	);

	// Interrupt status: one bit per event, cleared by writing one
	assign irq_events = {MEMORY_FAIL, LOOPBACK_FAIL, ADDR_PARITY_FAIL,
		TIMEOUT_BUS_A, TIMEOUT_BUS_B};
	assign irq_set_w = {11'h000, irq_events};
	bit_flag_cell #(
		.WIDTH(W)
	) u_irq_status (
		.clk(MCLK),
		.reset(RESET),
		.reset_value(16'h0000),
		.wr_en(wr_irq_status),
		.wr_one_clears(1'b1),
		.wr_data(WDATA),
		.hw_set(irq_set_w),
		.value(irq_status_w)
	);
	assign irq_status = irq_status_w[bit_status_pkg::IRQ_W-1:0];

	// Control bit 6 is stored for readback only: no buffered mode
	// Data path never stages words here
	assign nxt_control = wr_control ? WDATA : control_ff;
	assign nxt_irq_mask = wr_irq_mask ?
		WDATA[bit_status_pkg::IRQ_W-1:0] : irq_mask_ff;
	assign nxt_irq = |(irq_status & irq_mask_ff);

	assign nxt_rdata = !RD ? 16'h0000 :
		ADDR == bit_status_pkg::IDX_TEST_STATUS ? status_word :
		ADDR == bit_status_pkg::IDX_CONTROL ? control_ff :
		ADDR == bit_status_pkg::IDX_IRQ_STATUS ? irq_status_w :
		ADDR == bit_status_pkg::IDX_IRQ_MASK ?
			{11'h000, irq_mask_ff} : 16'h0000;

	// Reset loads control with CONTROL_RESET and the mask with IRQ_MASK_RESET
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			control_ff <= bit_status_pkg::CONTROL_RESET;
			irq_mask_ff <= bit_status_pkg::IRQ_MASK_RESET[bit_status_pkg::IRQ_W-1:0];
			rdata_ff <= 16'h0000;
			irq_ff <= 1'b0;
		end
		else
		begin
			control_ff <= nxt_control;
			irq_mask_ff <= nxt_irq_mask;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign RDATA = rdata_ff;
	assign IRQ = irq_ff;

	a_flag_set_wins: assert property (@(posedge MCLK) disable iff (RESET)
		MEMORY_FAIL |=> status_word[15])
		else $error("memory fail flag not set");
	a_loop_set: assert property (@(posedge MCLK) disable iff (RESET)
		LOOPBACK_FAIL |=> status_word[14])
		else $error("loopback fail flag not set");
	a_parity_set: assert property (@(posedge MCLK) disable iff (RESET)
		ADDR_PARITY_FAIL |=> status_word[13])
		else $error("address parity flag not set");
	a_test_bit_sw: assert property (@(posedge MCLK) disable iff (RESET)
		!wr_status |=> $stable(status_word[12]))
		else $error("test fail flag changed without write");
	a_chan_a_set: assert property (@(posedge MCLK) disable iff (RESET)
		TIMEOUT_BUS_A |=> status_word[11])
		else $error("bus A flag not set");
	a_chan_b_set: assert property (@(posedge MCLK) disable iff (RESET)
		TIMEOUT_BUS_B |=> status_word[10])
		else $error("bus B flag not set");
	a_user_field_sw: assert property (@(posedge MCLK) disable iff (RESET)
		!wr_status |=> $stable(status_word[9:0]))
		else $error("user field changed without write");
	a_write_replaces: assert property (@(posedge MCLK) disable iff (RESET)
		wr_status |=> (status_word & ~bit_status_pkg::HW_FLAG_MASK)
			== ($past(WDATA) & ~bit_status_pkg::HW_FLAG_MASK))
		else $error("write did not replace word");
	a_reset_value: assert property (@(posedge MCLK)
		RESET |=> status_word == {6'h00, bit_status_pkg::VERSION_CODE})
		else $error("reset value wrong");
	a_sticky_hold: assert property (@(posedge MCLK) disable iff (RESET)
		status_word[15] && !wr_status |=> status_word[15])
		else $error("flag dropped without write");
	a_read_data: assert property (@(posedge MCLK) disable iff (RESET)
		RD && ADDR == bit_status_pkg::IDX_TEST_STATUS
		|=> RDATA == $past(status_word))
		else $error("read of index 6 wrong");
	a_irq_level: assert property (@(posedge MCLK) disable iff (RESET)
		|(irq_status & irq_mask_ff) |=> IRQ)
		else $error("interrupt not raised");
endmodule

// ===== verification/cpu_model.sv
// Local CPU model driving the register port
`timescale 1ns/1ps
module cpu_model (
	input wire logic clk,
	output logic [3:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd
);
	initial
	begin
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One cycle; strobes set every call so none is assigned twice in a step
	task automatic put(input logic [3:0] a, input logic [15:0] d,
		input logic w, input logic r);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= r;
		@(posedge clk);
	endtask
	// Reset already clears control and mask; software writes them to zero again
	task automatic init();
		put(bit_status_pkg::IDX_CONTROL, 16'h0000, 1'b1, 1'b0);
		put(bit_status_pkg::IDX_IRQ_MASK, 16'h0000, 1'b1, 1'b0);
	endtask
endmodule

// ===== verification/builtin_test_status_word_tb.sv
// Self-checking bench for the test status word
`timescale 1ns/1ps
module builtin_test_status_word_tb;
	localparam logic [3:0] st = bit_status_pkg::IDX_TEST_STATUS;
	localparam logic [3:0] ctl = bit_status_pkg::IDX_CONTROL;
	localparam logic [3:0] ist = bit_status_pkg::IDX_IRQ_STATUS;
	localparam logic [3:0] msk = bit_status_pkg::IDX_IRQ_MASK;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic irq;
	logic [4:0] ev = 5'h00;
	logic rd_d = 1'b0;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h43fd;
	int err_total = 0;
	int checked = 0;
	int pos[5] = '{10, 11, 13, 14, 15};
	always #2 mclk = ~mclk;
	cpu_model cpu_u (.clk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd));
	builtin_test_status_word dut_u (.MCLK(mclk), .RESET(reset),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.MEMORY_FAIL(ev[4]), .LOOPBACK_FAIL(ev[3]),
		.ADDR_PARITY_FAIL(ev[2]), .TIMEOUT_BUS_A(ev[1]),
		.TIMEOUT_BUS_B(ev[0]), .IRQ(irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic cmp(input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch rdata exp %h got %h", e, s);
		end
	endtask
	// Sampled mid-cycle, then back on the rising edge for the next drive
	task automatic cmp_irq(input logic e);
		@(negedge mclk);
		checked++;
		if (irq !== e)
		begin
			err_total++;
			$display("mismatch irq exp %b got %b", e, irq);
		end
		@(posedge mclk);
	endtask
	task automatic end_sim();
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		cpu_u.put(a, d, 1'b1, 1'b0);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		cpu_u.put(a, 16'h0000, 1'b0, 1'b1);
	endtask
	task automatic idle();
		cpu_u.put(4'h0, 16'h0000, 1'b0, 1'b0);
	endtask
	always @(posedge mclk)
		rd_d <= rd;
	always @(negedge mclk)
		if (rd_d)
			cmp(exp_q.pop_front(), rdata);
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		rd_chk(st, {6'h00, bit_status_pkg::VERSION_CODE});
		rd_chk(ist, 16'h0000);
		cpu_u.init();
		wr_reg(4'h3, 16'hffff);
		rd_chk(4'h3, 16'h0000);
		wr_reg(ctl, 16'h0040);
		rd_chk(ctl, 16'h0040);
		for (int i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			wr_reg(st, seed[15:0]);
			rd_chk(st, seed[15:0]);
		end
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(st, 16'h0000);
			ev <= 5'h01 << i;
			idle();
			ev <= 5'h00;
			rd_chk(st, 16'h0001 << pos[i]);
		end
		ev <= 5'h1f;
		wr_reg(st, 16'h0000);
		ev <= 5'h00;
		rd_chk(st, 16'hec00);
		idle();
		rd_chk(st, 16'hec00);
		wr_reg(msk, 16'h001f);
		idle();
		cmp_irq(1'b1);
		rd_chk(ist, 16'h001f);
		wr_reg(ist, 16'h001f);
		idle();
		cmp_irq(1'b0);
		rd_chk(ist, 16'h0000);
		idle();
		end_sim();
	end
endmodule
